// ===== include/dadc_defines.vh
// Command codes, identification fields and status bit positions
`ifndef DADC_DEFINES_VH
`define DADC_DEFINES_VH
`define DADC_CMD_PREPARE    8'h60
`define DADC_CMD_DEVRESET   8'h6f
`define DADC_CMD_READID     8'h20
`define DADC_CMD_STORDIAG   8'h4e
`define DADC_CMD_GENDIAG    8'h41
`define DADC_CMD_CACHEDIAG  8'h42
`define DADC_CMD_SEEKADDR   8'h52
`define DADC_CMD_SEEKCTRL   8'h53
`define DADC_CMD_SENSE      8'h54
`define DADC_ID_CLASS       4'h3
`define DADC_ID_DIV2        3'h1
`define DADC_ID_DIV4        3'h2
`define DADC_CC_NONE        3'h0
`define DADC_CC_BUSY        3'h2
`define DADC_CC_ACCEPT      3'h7
`define DADC_CC_REJECT      3'h1
`define DADC_CC_TWO         3'h2
`define DADC_CC_EXCEPTION   3'h2
`define DADC_CC_DEVEND      3'h3
`define DADC_CACHE_LIMIT    5'h14
`define DADC_EQCHK_BIT      5
`define DADC_RECAL_BIT      15
`endif

// ===== logic/dadc_direct_command_unit.v
// Direct program command interpreter for a multi-unit disk attachment
`timescale 1ns/100ps
`default_nettype none
`include "dadc_defines.vh"
module dadc_direct_command_unit #(
  parameter       NUNITS  = 4,
  parameter [5:0] PRODUCT = 6'h2a   // Arbitrary product code
) (
  input  wire        mclk,
  input  wire        rst,
  // Command strobe from the channel
  input  wire        cmdValid,
  input  wire [7:0]  cmdCode,
  input  wire [1:0]  cmdUnit,
  input  wire [15:0] cmdData,
  input  wire [1:0]  cmdParity,
  output reg         cmdDone,
  output reg  [2:0]  cmdCc,
  output reg  [15:0] cmdRdata,
  // Configuration
  input  wire        divByFour,
  input  wire [3:0]  unitPresent,
  // Interrupt service
  input  wire        intAck,
  input  wire [1:0]  intAckUnit,
  output wire        intReq,
  output wire [3:0]  intLevel,
  output reg  [1:0]  intUnit,
  output reg  [2:0]  intCc,
  // Diagnostic engine start and kind; results presented with diagDone
  output reg         diagStart,
  output reg  [1:0]  diagKind,
  input  wire        diagDone,
  input  wire        diagFail,
  input  wire [4:0]  cachePages,
  input  wire [2:0]  cacheModules,
  // Disk unit side
  output reg         unitStrobe,
  output reg  [1:0]  unitSel,
  output reg  [1:0]  unitOp,
  output reg  [15:0] unitWord,
  input  wire        unitDone,
  input  wire [7:0]  unitSense,
  // Status words visible to status fetch
  output reg  [15:0] statusWord4,
  output reg  [15:0] statusWord6,
  output reg  [15:0] statusWord13,
  output wire [31:0] senseBytes
);

  // ==========================================================================
  // Encodings
  localparam ST_IDLE  = 2'h0;
  localparam ST_DIAG  = 2'h1;
  localparam ST_UNIT  = 2'h2;
  localparam OP_ADDR  = 2'h0;
  localparam OP_SEEK  = 2'h1;
  localparam OP_DIAG  = 2'h2;
  localparam OP_SENSE = 2'h3;
  localparam DK_GEN   = 2'h1;
  localparam DK_CACHE = 2'h2;
  localparam DK_STOR  = 2'h3;

  // ==========================================================================
  // Registers
  reg [1:0]  state_ff;
  reg [1:0]  curUnit_ff;
  reg [3:0]  level_ff;
  reg [3:0]  enable_ff;
  reg [3:0]  pending_ff;
  reg [11:0] pendCc_ff;
  reg [31:0] sense_ff;
  reg        parErr_ff;
  reg [7:0]  cylLow_ff;
  reg [1:0]  opCode;
  reg [15:0] opWord;
  reg [2:0]  respCc;
  reg [2:0]  finishCc;

  // ==========================================================================
  // Command decode
  wire        parOk    = (^cmdData[15:8] ^ cmdParity[1]) & (^cmdData[7:0] ^ cmdParity[0]);
  wire        present  = unitPresent[cmdUnit];
  wire        busy     = state_ff != ST_IDLE;
  wire        isRst    = cmdValid && cmdCode == `DADC_CMD_DEVRESET;
  wire        live     = cmdValid && !isRst && present;
  wire        isPrep   = live && cmdCode == `DADC_CMD_PREPARE;
  wire        isId     = live && cmdCode == `DADC_CMD_READID;
  wire        isDiag   = cmdCode == `DADC_CMD_STORDIAG || cmdCode == `DADC_CMD_GENDIAG
                      || cmdCode == `DADC_CMD_CACHEDIAG;
  wire        isUnitOp = cmdCode == `DADC_CMD_SEEKADDR || cmdCode == `DADC_CMD_SEEKCTRL
                      || cmdCode == `DADC_CMD_SENSE;
  wire        known    = isDiag || isUnitOp;
  wire        startOp  = live && !busy && known;
  wire        recal    = cmdData[`DADC_RECAL_BIT];
  wire [1:0]  kindCode = cmdCode == `DADC_CMD_STORDIAG ? DK_STOR
                       : cmdCode == `DADC_CMD_CACHEDIAG ? DK_CACHE : DK_GEN;

  // ==========================================================================
  // Identification word
  wire [15:0] idWord = {`DADC_ID_CLASS, 1'b0,
                        divByFour ? `DADC_ID_DIV4 : `DADC_ID_DIV2,
                        PRODUCT, 1'b1, 1'b0};

  // ==========================================================================
  // Completion of diagnostic and unit work
  // Reset of another unit must not swallow this unit's done pulse
  wire        rstHit     = isRst && cmdUnit == curUnit_ff;
  wire        diagFinish = state_ff == ST_DIAG && diagDone && !rstHit;
  wire        unitFinish = state_ff == ST_UNIT && unitDone && !rstHit;
  wire        cacheRun   = diagKind == DK_CACHE;
  wire        cacheOver  = cacheRun && cachePages > `DADC_CACHE_LIMIT;
  wire        diagBad    = diagFail || parErr_ff;

  always @* begin
    if (unitFinish)
      finishCc = `DADC_CC_DEVEND;
    else if (cacheOver)
      finishCc = `DADC_CC_TWO;
    else if (diagBad)
      finishCc = `DADC_CC_EXCEPTION;
    else
      finishCc = `DADC_CC_DEVEND;
  end

  // ==========================================================================
  // Interrupt presentation
  wire [NUNITS-1:0] unitActive;
  genvar g;
  generate
    for (g = 0; g < NUNITS; g = g + 1) begin : gUnit
      assign unitActive[g] = pending_ff[g] & enable_ff[g];
    end
  endgenerate

  assign intLevel   = level_ff;
  assign intReq     = |unitActive;
  assign senseBytes = sense_ff;

  // Lowest active unit is presented first
  integer i;
  always @* begin
    intUnit = 2'h0;
    intCc   = 3'h0;
    for (i = NUNITS - 1; i >= 0; i = i - 1) begin
      if (unitActive[i]) begin
        intUnit = i[1:0];
        intCc   = pendCc_ff[3*i +: 3];
      end
    end
  end

  // ==========================================================================
  // Word and operation sent to the disk unit
  always @* begin
    opCode = OP_ADDR;
    opWord = {8'h00, cmdData[7:0]};
    case (cmdCode)
      `DADC_CMD_SEEKCTRL: begin
        // High cylinder bit and heads, joined with stored low byte
        opCode = recal ? OP_DIAG : OP_SEEK;
        opWord = recal ? cmdData : {cmdData[15:8], cylLow_ff};
      end
      `DADC_CMD_SENSE: begin
        opCode = OP_SENSE;
        opWord = 16'h0000;
      end
      default: ;
    endcase
  end

  // ==========================================================================
  // Condition code of the command answer
  always @* begin
    if (isRst)
      respCc = `DADC_CC_ACCEPT;
    else if (!present)
      respCc = `DADC_CC_NONE;
    else if (isPrep || isId)
      respCc = `DADC_CC_ACCEPT;
    else if (busy)
      respCc = `DADC_CC_BUSY;
    else if (known)
      respCc = `DADC_CC_ACCEPT;
    else
      respCc = `DADC_CC_REJECT;
  end

  // ==========================================================================
  // Interrupt preparation, kept across device reset
  always @(posedge mclk) begin
    if (rst) begin
      level_ff  <= 4'h0;
      enable_ff <= 4'h0;
    end else if (isPrep) begin
      level_ff           <= cmdData[4:1];
      enable_ff[cmdUnit] <= cmdData[0];
    end
  end

  // ==========================================================================
  // Pending interrupts; a completion in the same cycle as an ack wins
  always @(posedge mclk) begin
    if (rst) begin
      pending_ff <= 4'h0;
      pendCc_ff  <= 12'h000;
    end else begin
      if (intAck && enable_ff[intAckUnit])
        pending_ff[intAckUnit] <= 1'b0;
      if (isRst) begin
        pending_ff[cmdUnit]       <= 1'b0;
        pendCc_ff[3*cmdUnit +: 3] <= 3'h0;
      end
      if (diagFinish || unitFinish) begin
        pending_ff[curUnit_ff]       <= 1'b1;
        pendCc_ff[3*curUnit_ff +: 3] <= finishCc;
      end
    end
  end

  // ==========================================================================
  // Command sequencer
  always @(posedge mclk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      curUnit_ff <= 2'h0;
      parErr_ff  <= 1'b0;
      cylLow_ff  <= 8'h00;
      diagStart  <= 1'b0;
      diagKind   <= 2'h0;
      unitStrobe <= 1'b0;
      unitSel    <= 2'h0;
      unitOp     <= 2'h0;
      unitWord   <= 16'h0000;
    end else begin
      diagStart  <= 1'b0;
      unitStrobe <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (startOp && isDiag) begin
            curUnit_ff <= cmdUnit;
            unitSel    <= cmdUnit;
            parErr_ff  <= cmdCode == `DADC_CMD_STORDIAG && !parOk;
            diagKind   <= kindCode;
            diagStart  <= 1'b1;
            state_ff   <= ST_DIAG;
          end else if (startOp) begin
            curUnit_ff <= cmdUnit;
            unitSel    <= cmdUnit;
            unitOp     <= opCode;
            unitWord   <= opWord;
            unitStrobe <= 1'b1;
            state_ff   <= ST_UNIT;
            if (cmdCode == `DADC_CMD_SEEKADDR)
              cylLow_ff <= cmdData[7:0];
          end
        end
        ST_DIAG: begin
          if (rstHit || diagFinish)
            state_ff <= ST_IDLE;
        end
        ST_UNIT: begin
          if (rstHit || unitFinish)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Command answer
  always @(posedge mclk) begin
    if (rst) begin
      cmdDone  <= 1'b0;
      cmdCc    <= 3'h0;
      cmdRdata <= 16'h0000;
    end else begin
      cmdDone <= cmdValid;
      if (cmdValid) begin
        cmdCc    <= respCc;
        cmdRdata <= isId ? idWord : 16'h0000;
      end
    end
  end

  // ==========================================================================
  // Status words and sense bytes
  always @(posedge mclk) begin
    if (rst) begin
      statusWord4  <= 16'h0000;
      statusWord6  <= 16'h0000;
      statusWord13 <= 16'h0000;
      sense_ff     <= 32'h0000_0000;
    end else begin
      if (isRst) begin
        statusWord4              <= 16'h0000;
        sense_ff[8*cmdUnit +: 8] <= 8'h00;
      end
      if (diagFinish && cacheRun) begin
        statusWord13[12:8] <= cachePages;
        statusWord6[10:8]  <= cacheModules;
      end
      if (diagFinish && (cacheOver || diagBad))
        statusWord4[`DADC_EQCHK_BIT] <= 1'b1;
      if (unitFinish && unitOp == OP_SENSE)
        sense_ff[8*curUnit_ff +: 8] <= unitSense;
    end
  end

endmodule // dadc_direct_command_unit
`default_nettype wire

// ===== sim/dadc_checker.sv
// Port assertions for the direct command unit
`timescale 1ns/100ps
`default_nettype none
`include "dadc_defines.vh"
module dadc_checker #(parameter [5:0] PRODUCT = 6'h2a) (
  input wire logic        mclk, rst, cmdValid, cmdDone, divByFour, unitStrobe, diagDone,
  input wire logic [7:0]  cmdCode,
  input wire logic [1:0]  cmdUnit, diagKind,
  input wire logic [15:0] cmdData, cmdRdata, statusWord4, statusWord6, statusWord13,
  input wire logic [2:0]  cmdCc, cacheModules,
  input wire logic [3:0]  unitPresent, intLevel,
  input wire logic [4:0]  cachePages
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take(logic [7:0] code);
    cmdValid && cmdCode == code && unitPresent[cmdUnit];
  endsequence
  sequence s_cache;
    diagDone && diagKind == 2'h2;
  endsequence
  a_done_next: assert property (cmdValid |=> cmdDone) else $error("no done after command");
  a_done_cause: assert property (cmdDone |-> $past(cmdValid)) else $error("stray done");
  a_level_load: assert property (s_take(`DADC_CMD_PREPARE) |=> intLevel == $past(cmdData[4:1]))
    else $error("level not loaded");
  a_level_kept: assert property (!$past(cmdValid) |-> $stable(intLevel))
    else $error("level moved");
  a_id_word: assert property (s_take(`DADC_CMD_READID) |=> cmdRdata == {4'h3, 1'h0,
    ($past(divByFour) ? 3'h2 : 3'h1), PRODUCT, 2'h2}) else $error("bad id word");
  a_id_absent: assert property (cmdValid && cmdCode == `DADC_CMD_READID && !unitPresent[cmdUnit]
    |=> cmdCc == 3'h0) else $error("absent unit cc");
  a_reset_taken: assert property (s_take(`DADC_CMD_DEVRESET) |=> cmdCc == `DADC_CC_ACCEPT)
    else $error("reset refused");
  a_cache_count: assert property (s_cache |=> statusWord13[12:8] == $past(cachePages)
    && statusWord6[10:8] == $past(cacheModules)) else $error("cache status wrong");
  a_cache_limit: assert property (s_cache ##0 cachePages > 5'h14 |=> statusWord4[5])
    else $error("no equipment check");
  a_strobe_cause: assert property (unitStrobe |-> $past(cmdValid && cmdCode[7:4] == 4'h5))
    else $error("stray unit strobe");
endmodule // dadc_checker
`default_nettype wire

// ===== sim/dadc_partner.sv
// Diagnostic engine and disk unit responder model
`timescale 1ns/100ps
`default_nettype none
module dadc_partner #(parameter int DLY = 4) (
  input wire logic       mclk, rst, diagStart, unitStrobe, failSet,
  input wire logic [4:0] pagesSet,
  input wire logic [2:0] modsSet,
  input wire logic [7:0] senseSet,
  output logic           diagDone, diagFail, unitDone,
  output logic [4:0]     cachePages,
  output logic [2:0]     cacheModules,
  output logic [7:0]     unitSense
);
  int dCnt = 0;
  int uCnt = 0;
  always @(posedge mclk) begin
    dCnt <= rst ? 0 : diagStart ? DLY : dCnt - (dCnt != 0);
    uCnt <= rst ? 0 : unitStrobe ? DLY : uCnt - (uCnt != 0);
  end
  assign diagDone = dCnt == 1;
  assign unitDone = uCnt == 1;
  // Results valid only with their done pulse
  assign diagFail = diagDone ? failSet : ~failSet;
  assign cachePages = diagDone ? pagesSet : ~pagesSet;
  assign cacheModules = diagDone ? modsSet : ~modsSet;
  assign unitSense = unitDone ? senseSet : ~senseSet;
endmodule // dadc_partner
`default_nettype wire

// ===== sim/tb_dadc_direct_command_unit.sv
// Self-checking bench for the direct command unit
`timescale 1ns/100ps
`default_nettype none
`include "dadc_defines.vh"
module tb_dadc_direct_command_unit;
  localparam [5:0] PROD = 6'h15; // Arbitrary product code
  logic mclk = 0, rst = 1, cmdValid = 0, divByFour = 1, intAck = 0, failSet = 0;
  logic [7:0] cmdCode = 0, senseSet = 8'h5a;
  logic [1:0] cmdUnit = 0, cmdParity = 0, intAckUnit = 0, parFlip = 0;
  logic [15:0] cmdData = 0, rd, uw;
  logic [3:0] unitPresent = 4'h7;
  logic [4:0] pagesSet = 0, us;
  logic [2:0] modsSet = 0, cc;
  wire logic cmdDone, intReq, diagStart, diagDone, diagFail, unitStrobe, unitDone;
  wire logic [2:0] cmdCc, intCc, cacheModules;
  wire logic [15:0] cmdRdata, statusWord4, statusWord6, statusWord13, unitWord;
  wire logic [3:0] intLevel;
  wire logic [1:0] intUnit, diagKind, unitSel, unitOp;
  wire logic [4:0] cachePages;
  wire logic [7:0] unitSense;
  wire logic [31:0] senseBytes;
  int err_count = 0, checked = 0;
  always #5 mclk = ~mclk;
  dadc_direct_command_unit #(.PRODUCT(PROD)) uut (.*);
  dadc_partner pm (.*);
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(logic [7:0] c, logic [1:0] u, logic [15:0] d);
    cmdValid <= 1;
    cmdCode <= c;
    cmdUnit <= u;
    cmdData <= d;
    cmdParity <= {~^d[15:8], ~^d[7:0]} ^ parFlip;
    @(posedge mclk);
    cmdValid <= 0;
    #1 cc = cmdCc;
    rd = cmdRdata;
    us = {unitStrobe, unitOp, unitSel};
    uw = unitWord;
    chk("cmdDone", 1, cmdDone);
    @(posedge mclk);
  endtask
  task automatic waitInt(logic e);
    for (int i = 0; i < 12 && intReq !== 1'b1; i++) @(negedge mclk);
    chk("intReq", e, intReq);
    @(posedge mclk);
  endtask
  task automatic ack(logic [1:0] u);
    intAck <= 1;
    intAckUnit <= u;
    @(posedge mclk);
    intAck <= 0;
    @(negedge mclk);
    chk("ackClear", 0, intReq);
    @(posedge mclk);
  endtask
  task automatic t_prepare;
    cmd(`DADC_CMD_PREPARE, 2'h1, 16'h000a);
    chk("level", 4'h5, intLevel);
    cmd(`DADC_CMD_PREPARE, 2'h0, 16'h0015);
    chk("level", 4'ha, intLevel);
    $display("test prepare ended");
  endtask
  task automatic t_id;
    cmd(`DADC_CMD_READID, 2'h0, 16'h0000);
    chk("idDiv4", {4'h3, 1'h0, 3'h2, PROD, 2'h2}, rd);
    cmd(`DADC_CMD_READID, 2'h3, 16'h0000);
    chk("ccAbsent", 0, cc);
    divByFour <= 0;
    cmd(`DADC_CMD_READID, 2'h0, 16'h0000);
    chk("idDiv2", {4'h3, 1'h0, 3'h1, PROD, 2'h2}, rd);
    cmd(`DADC_CMD_READID, 2'h1, 16'h0000);
    chk("ccPresent", 7, cc);
    $display("test identification ended");
  endtask
  task automatic t_seek;
    cmd(`DADC_CMD_SEEKADDR, 2'h0, 16'h00c3);
    chk("seekAddr", 5'h10, us);
    waitInt(1);
    ack(0);
    cmd(`DADC_CMD_SEEKCTRL, 2'h0, 16'h0780);
    chk("seekCtrl", 5'h14, us);
    chk("seekWord", 16'h07c3, uw);
    waitInt(1);
    ack(0);
    cmd(`DADC_CMD_SEEKCTRL, 2'h0, 16'h8000);
    chk("diagCtrl", 5'h18, us);
    waitInt(1);
    ack(0);
    cmd(`DADC_CMD_SENSE, 2'h0, 16'h0000);
    waitInt(1);
    chk("sense", senseSet, senseBytes[7:0]);
    ack(0);
    $display("test seek ended");
  endtask
  task automatic t_mask;
    cmd(`DADC_CMD_SENSE, 2'h1, 16'h0000);
    waitInt(0);
    cmd(`DADC_CMD_PREPARE, 2'h1, 16'h0015);
    waitInt(1);
    chk("intUnit", 2'h1, intUnit);
    ack(1);
    $display("test masking ended");
  endtask
  task automatic t_diag;
    failSet <= 1;
    cmd(`DADC_CMD_GENDIAG, 2'h0, 16'h0000);
    waitInt(1);
    chk("genEqChk", 1, statusWord4[5]);
    cmd(`DADC_CMD_DEVRESET, 2'h0, 16'h0000);
    cmd(`DADC_CMD_STORDIAG, 2'h0, 16'h1234);
    waitInt(1);
    chk("storEqChk", 1, statusWord4[5]);
    chk("storExc", `DADC_CC_EXCEPTION, intCc);
    cmd(`DADC_CMD_DEVRESET, 2'h0, 16'h0000);
    failSet <= 0;
    parFlip = 2'h1;
    cmd(`DADC_CMD_STORDIAG, 2'h0, 16'h0000);
    parFlip = 2'h0;
    waitInt(1);
    chk("parExc", `DADC_CC_EXCEPTION, intCc);
    cmd(`DADC_CMD_DEVRESET, 2'h0, 16'h0000);
    cmd(`DADC_CMD_STORDIAG, 2'h0, 16'h0000);
    waitInt(1);
    chk("storEnd", `DADC_CC_DEVEND, intCc);
    ack(0);
    $display("test diagnostics ended");
  endtask
  task automatic t_cache;
    pagesSet <= 5'h15;
    modsSet <= 3'h5;
    cmd(`DADC_CMD_CACHEDIAG, 2'h0, 16'h0000);
    waitInt(1);
    chk("pages", 5'h15, statusWord13[12:8]);
    chk("modules", 3'h5, statusWord6[10:8]);
    chk("cacheEqChk", 1, statusWord4[5]);
    chk("cacheCc", 2, intCc);
    cmd(`DADC_CMD_DEVRESET, 2'h0, 16'h0000);
    chk("rstCc", `DADC_CC_ACCEPT, cc);
    chk("rstInt", 0, intReq);
    chk("rstStat", 0, statusWord4);
    chk("keepLevel", 4'ha, intLevel);
    $display("test cache ended");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_prepare;
    t_id;
    t_seek;
    t_mask;
    t_diag;
    t_cache;
    test_done;
  end
endmodule // tb_dadc_direct_command_unit
bind dadc_direct_command_unit dadc_checker #(.PRODUCT(PRODUCT)) chkI (.*);
`default_nettype wire
